// >>> ssr_pkg.sv
`default_nettype none
package ssr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CFG  = 8'h00;
	localparam logic [7:0] OFS_LEN  = 8'h04;
	localparam logic [7:0] OFS_SN   = 8'h08;
	localparam logic [7:0] OFS_POS  = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	// Register select codes
	typedef enum logic [2:0] {
		SEL_CFG, SEL_LEN, SEL_SN, SEL_POS, SEL_STAT, SEL_CTRL, SEL_NONE
	} ssr_sel_t;
	// Encoder configuration fields
	localparam int CFG_RATE_LSB = 7;
	localparam int CFG_NO_INCR  = 9;
	localparam int CFG_BINARY   = 10;
	localparam int CFG_FIR      = 11;
	localparam int CFG_PAR_EN   = 12;
	localparam int CFG_PAR_EVEN = 13;
	localparam int CFG_ALM_EN   = 14;
	localparam int CFG_SSI      = 15;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] LEN_RST = 16'h0019;
	localparam logic [15:0] LEN_MAX = 16'h0019;
	localparam logic [5:0]  SN_BITS = 6'h20;
	// Control and status fields
	localparam int CTRL_ABS = 0;
	localparam int CTRL_BOOT = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_PARERR = 2;
	localparam int ST_CFGBAD = 3;
	localparam int ST_SNVALID = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Link clock rates
	localparam logic [1:0] RATE_100K = 2'h0;
	localparam logic [1:0] RATE_500K = 2'h1;
	localparam logic [1:0] RATE_1M   = 2'h2;
	localparam int LNK_PERIOD_NS = 160;
	localparam int HZ_100K = 100000;
	localparam int HZ_500K = 500000;
	localparam int HZ_1M   = 1000000;
	localparam int HZ_2M   = 2000000;
	localparam int NS_PER_S = 1000000000;
	// Half periods round down: a longest time
	localparam int HALF_100K = NS_PER_S / (2 * HZ_100K) / LNK_PERIOD_NS;
	localparam int HALF_500K = NS_PER_S / (2 * HZ_500K) / LNK_PERIOD_NS;
	localparam int HALF_1M   = NS_PER_S / (2 * HZ_1M) / LNK_PERIOD_NS;
	localparam int HALF_2M_R = NS_PER_S / (2 * HZ_2M) / LNK_PERIOD_NS;
	localparam int HALF_2M   = (HALF_2M_R < 1) ? 1 : HALF_2M_R;
	// Idle time before next frame rounds up
	localparam int IDLE_NS  = 30000;
	localparam int IDLE_CYC = (IDLE_NS + LNK_PERIOD_NS - 1) / LNK_PERIOD_NS;
	// Link cycles that data needs to cross the input synchroniser
	localparam logic [7:0] SYNC_LAG = 8'h02;
	typedef enum logic [1:0] {S_IDLE, S_SN_WAIT, S_RUN, S_POS_WAIT} ssr_sys_t;
	typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_MONO} ssr_lnk_t;
	// Half period in link cycles per rate code
	function automatic logic [7:0] ssr_half(input logic [1:0] rate);
		unique case (rate)
			RATE_100K: ssr_half = 8'(HALF_100K);
			RATE_500K: ssr_half = 8'(HALF_500K);
			RATE_1M:   ssr_half = 8'(HALF_1M);
			default:   ssr_half = 8'(HALF_2M);
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> ssr_reader.sv
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssr_reader import ssr_pkg::*; (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        lnk_clk_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output var  logic        s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output var  logic        s_axi_wready_out,
	output var  logic [1:0]  s_axi_bresp_out,
	output var  logic        s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output var  logic        s_axi_arready_out,
	output var  logic [31:0] s_axi_rdata_out,
	output var  logic [1:0]  s_axi_rresp_out,
	output var  logic        s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output var  logic        ssi_clk_out,
	input  wire logic        ssi_data_in,
	output var  logic        enc_alarm_out
);
	// Address decode, shared by read and write
	function automatic ssr_sel_t reg_sel(input logic [7:0] a);
		unique case (a)
			OFS_CFG:  reg_sel = SEL_CFG;
			OFS_LEN:  reg_sel = SEL_LEN;
			OFS_SN:   reg_sel = SEL_SN;
			OFS_POS:  reg_sel = SEL_POS;
			OFS_STAT: reg_sel = SEL_STAT;
			OFS_CTRL: reg_sel = SEL_CTRL;
			default:  reg_sel = SEL_NONE;
		endcase
	endfunction

	// Gray to binary, zeros above the word do no harm
	function automatic logic [31:0] gray2bin(input logic [31:0] g);
		logic [31:0] b;
		b = 32'h0000_0000;
		b[31] = g[31];
		for (int i = 30; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	logic [15:0] cfg_q, len_q;
	logic [1:0]  ctrl_q;
	logic        boot_pend_q;
	logic [31:0] sn_q, pos_q;
	logic        alarm_q, par_err_q, cfg_bad_q, sn_valid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	ssr_sys_t    st_q;
	logic        req_tgl_q, req_sn_q;
	logic [5:0]  req_bits_q;
	logic [1:0]  req_rate_q;
	logic        dn_s1_q, dn_s2_q, dn_seen_q;
	// Link domain state
	ssr_lnk_t    lk_st_q;
	logic        lk_r1_q, lk_r2_q;
	logic        rq_s1_q, rq_s2_q, rq_seen_q;
	logic        dat_s1_q, dat_s2_q;
	logic [7:0]  lk_cnt_q, lk_half_q;
	logic [5:0]  lk_bits_q, lk_nbits_q;
	logic [31:0] lk_shift_q;
	logic        dn_tgl_q;
	logic        lk_take;

	// Frame health and decode of the held word
	logic        cfg_ok, res_take, wr_fire, boot_set;
	logic [5:0]  len_eff;
	logic [1:0]  tail;
	logic [31:0] pos_raw, pos_dec;
	logic        alm_bit, par_ok;
	ssr_sel_t    wsel;
	assign len_eff = (len_q > LEN_MAX) ? LEN_MAX[5:0] : len_q[5:0];
	assign cfg_ok  = cfg_q[CFG_SSI] & cfg_q[CFG_NO_INCR]
		& ~cfg_q[CFG_FIR] & (len_eff != 6'h00);
	assign res_take = dn_s2_q != dn_seen_q;
	assign tail    = {1'b0, cfg_q[CFG_ALM_EN]} + {1'b0, cfg_q[CFG_PAR_EN]};
	assign pos_raw = lk_shift_q >> tail;
	assign pos_dec = cfg_q[CFG_BINARY] ? pos_raw : gray2bin(pos_raw);
	assign alm_bit = cfg_q[CFG_PAR_EN] ? lk_shift_q[1] : lk_shift_q[0];
	assign par_ok  = ~cfg_q[CFG_PAR_EN]
		| ((^lk_shift_q) ^ cfg_q[CFG_PAR_EVEN]);
	assign wsel    = reg_sel(awaddr_q);
	assign wr_fire = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
	assign boot_set = wr_fire & (wsel == SEL_CTRL) & wstrb_q[0]
		& wdata_q[CTRL_BOOT];

	// Write address and data, taken in either order
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				awaddr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// Register writes and write response
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg_q  <= CFG_RST;
			len_q  <= LEN_RST;
			ctrl_q <= 2'h1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (wsel == SEL_CFG && wstrb_q[0]) cfg_q[7:0] <= wdata_q[7:0];
			if (wsel == SEL_CFG && wstrb_q[1]) cfg_q[15:8] <= wdata_q[15:8];
			if (wsel == SEL_LEN && wstrb_q[0]) len_q[7:0] <= wdata_q[7:0];
			if (wsel == SEL_LEN && wstrb_q[1]) len_q[15:8] <= wdata_q[15:8];
			if (wsel == SEL_CTRL && wstrb_q[0]) ctrl_q[CTRL_ABS] <= wdata_q[CTRL_ABS];
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Reads answer one cycle after the address is taken
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= RESP_OKAY;
			unique case (reg_sel(s_axi_araddr_in))
				SEL_CFG:  s_axi_rdata_out <= {16'h0000, cfg_q};
				SEL_LEN:  s_axi_rdata_out <= {16'h0000, len_q};
				SEL_SN:   s_axi_rdata_out <= sn_q;
				SEL_POS:  s_axi_rdata_out <= pos_q;
				SEL_STAT: s_axi_rdata_out <= {27'h0, sn_valid_q, cfg_bad_q,
					par_err_q, alarm_q, req_tgl_q ^ dn_seen_q};
				SEL_CTRL: s_axi_rdata_out <= {30'h0, boot_pend_q, ctrl_q[CTRL_ABS]};
				SEL_NONE: begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	// Done toggle from the link, two stages before use
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dn_s1_q   <= 1'b0;
			dn_s2_q   <= 1'b0;
			dn_seen_q <= 1'b0;
		end else begin
			dn_s1_q   <= dn_tgl_q;
			dn_s2_q   <= dn_s1_q;
			dn_seen_q <= dn_s2_q;
		end
	end

	// Start-up step pending; a new write beats the take
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			boot_pend_q <= 1'b1;
		end else if (boot_set) begin
			boot_pend_q <= 1'b1;
		end else if (st_q == S_IDLE) begin
			boot_pend_q <= 1'b0;
		end
	end

	// Sequencer: serial number at start-up, then positions
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q       <= S_IDLE;
			req_tgl_q  <= 1'b0;
			req_sn_q   <= 1'b0;
			req_bits_q <= 6'h00;
			req_rate_q <= RATE_100K;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (ctrl_q[CTRL_ABS] && cfg_ok) begin
						req_rate_q <= cfg_q[CFG_RATE_LSB +: 2];
						req_bits_q <= SN_BITS;
						req_sn_q   <= 1'b1;
						req_tgl_q  <= ~req_tgl_q;
						st_q       <= S_SN_WAIT;
					end else begin
						st_q <= S_RUN;
					end
				end
				S_SN_WAIT: if (res_take) st_q <= S_RUN;
				S_RUN: begin
					if (boot_pend_q) begin
						st_q <= S_IDLE;
					end else if (cfg_ok) begin
						// Rate moves only with a request, never mid-frame
						req_rate_q <= cfg_q[CFG_RATE_LSB +: 2];
						req_bits_q <= len_eff;
						req_sn_q   <= 1'b0;
						req_tgl_q  <= ~req_tgl_q;
						st_q       <= S_POS_WAIT;
					end
				end
				S_POS_WAIT: if (res_take) st_q <= S_RUN;
			endcase
		end
	end

	// Serial number capture; zero for incremental systems
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sn_q       <= 32'h0000_0000;
			sn_valid_q <= 1'b0;
		end else if (st_q == S_IDLE) begin
			sn_q       <= 32'h0000_0000;
			sn_valid_q <= ~ctrl_q[CTRL_ABS];
		end else if (st_q == S_SN_WAIT && res_take) begin
			sn_q       <= lk_shift_q;
			sn_valid_q <= 1'b1;
		end
	end

	// Position decode, alarm and parity per frame
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pos_q         <= 32'h0000_0000;
			alarm_q       <= 1'b0;
			par_err_q     <= 1'b0;
			enc_alarm_out <= 1'b0;
		end else if (st_q == S_POS_WAIT && res_take) begin
			pos_q         <= pos_dec;
			alarm_q       <= cfg_q[CFG_ALM_EN] & alm_bit;
			enc_alarm_out <= cfg_q[CFG_ALM_EN] & alm_bit;
			par_err_q     <= ~par_ok;
		end
	end

	// Refused setups show in status
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg_bad_q <= 1'b0;
		end else begin
			cfg_bad_q <= ~cfg_ok;
		end
	end

	// Link reset: async assert, release synchronised
	always_ff @(posedge lnk_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lk_r1_q <= 1'b0;
			lk_r2_q <= 1'b0;
		end else begin
			lk_r1_q <= 1'b1;
			lk_r2_q <= lk_r1_q;
		end
	end

	// Request toggle and encoder data, two stages each
	always_ff @(posedge lnk_clk_in or negedge lk_r2_q) begin
		if (!lk_r2_q) begin
			rq_s1_q  <= 1'b0;
			rq_s2_q  <= 1'b0;
			dat_s1_q <= 1'b1;
			dat_s2_q <= 1'b1;
		end else begin
			rq_s1_q  <= req_tgl_q;
			rq_s2_q  <= rq_s1_q;
			dat_s1_q <= ssi_data_in;
			dat_s2_q <= dat_s1_q;
		end
	end

	// Sample point: slow rates settle within their own high phase,
	// the fastest only one phase later because of the sync lag
	assign lk_take = (lk_half_q > SYNC_LAG) ? (lk_bits_q != lk_nbits_q)
		: (lk_bits_q != 6'h00);

	// Frame engine; request fields stay still until done
	// Limitation: the data path lags two link cycles
	always_ff @(posedge lnk_clk_in or negedge lk_r2_q) begin
		if (!lk_r2_q) begin
			lk_st_q    <= L_IDLE;
			rq_seen_q  <= 1'b0;
			lk_cnt_q   <= 8'h00;
			lk_half_q  <= 8'h01;
			lk_bits_q  <= 6'h00;
			lk_nbits_q <= 6'h00;
			lk_shift_q <= 32'h0000_0000;
			ssi_clk_out <= 1'b1;
			dn_tgl_q   <= 1'b0;
		end else begin
			unique case (lk_st_q)
				L_IDLE: if (rq_s2_q != rq_seen_q) begin
					rq_seen_q  <= rq_s2_q;
					lk_nbits_q <= req_bits_q;
					lk_half_q  <= ssr_half(req_rate_q);
					lk_cnt_q   <= ssr_half(req_rate_q);
					lk_bits_q  <= 6'h00;
					lk_shift_q <= 32'h0000_0000;
					ssi_clk_out <= 1'b0; // First fall latches the word
					lk_st_q    <= L_LOW;
				end
				L_LOW: if (lk_cnt_q == 8'h01) begin
					ssi_clk_out <= 1'b1;
					lk_cnt_q   <= lk_half_q;
					lk_st_q    <= L_HIGH;
				end else begin
					lk_cnt_q <= lk_cnt_q - 8'h01;
				end
				L_HIGH: if (lk_cnt_q == 8'h01) begin
					if (lk_take) begin
						lk_shift_q <= {lk_shift_q[30:0], dat_s2_q};
					end
					if (lk_bits_q == lk_nbits_q) begin
						lk_cnt_q <= 8'(IDLE_CYC);
						lk_st_q  <= L_MONO;
					end else begin
						ssi_clk_out <= 1'b0;
						lk_bits_q  <= lk_bits_q + 6'h01;
						lk_cnt_q   <= lk_half_q;
						lk_st_q    <= L_LOW;
					end
				end else begin
					lk_cnt_q <= lk_cnt_q - 8'h01;
				end
				L_MONO: if (lk_cnt_q == 8'h01) begin
					dn_tgl_q <= ~dn_tgl_q;
					lk_st_q  <= L_IDLE;
				end else begin
					lk_cnt_q <= lk_cnt_q - 8'h01;
				end
			endcase
		end
	end

	// Checks on the link side
	a_rate_half: assert property (@(posedge lnk_clk_in) disable iff (!lk_r2_q)
		lk_st_q != L_IDLE && lk_st_q != L_MONO
		|-> lk_half_q == ssr_half(req_rate_q) && lk_cnt_q <= lk_half_q)
		else $error("link half period off the rate table");
	a_frame_bits: assert property (@(posedge lnk_clk_in) disable iff (!lk_r2_q)
		$rose(lk_st_q == L_MONO) |-> lk_bits_q == lk_nbits_q)
		else $error("frame ended with wrong bit count");
	a_idle_high: assert property (@(posedge lnk_clk_in) disable iff (!lk_r2_q)
		lk_st_q == L_MONO |-> ssi_clk_out ##1 (ssi_clk_out || lk_st_q == L_LOW))
		else $error("clock not idling high after frame");
	a_msb_shift: assert property (@(posedge lnk_clk_in) disable iff (!lk_r2_q)
		lk_st_q == L_HIGH && lk_cnt_q == 8'h01 && lk_take
		|=> lk_shift_q[0] == $past(dat_s2_q)
			&& lk_shift_q[31:1] == $past(lk_shift_q[30:0]))
		else $error("bit not shifted in at the low end");
	// Checks on the register side
	a_run_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		st_q == S_RUN && !cfg_ok |=> st_q != S_POS_WAIT)
		else $error("frame started with refused setup");
	a_fir_refused: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		cfg_q[CFG_FIR] |=> cfg_bad_q)
		else $error("fir-tree layout not flagged");
	a_parity_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		st_q == S_POS_WAIT && res_take && cfg_q[CFG_PAR_EN]
		|=> par_err_q == ~($past(^lk_shift_q) ^ $past(cfg_q[CFG_PAR_EVEN])))
		else $error("parity verdict wrong");
	a_alarm_report: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		st_q == S_POS_WAIT && res_take |=> enc_alarm_out == alarm_q
		&& alarm_q == ($past(cfg_q[CFG_ALM_EN]) && $past(alm_bit)))
		else $error("alarm bit not reported");
	a_serial_take: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		st_q == S_SN_WAIT && res_take |=> sn_q == $past(lk_shift_q) && sn_valid_q)
		else $error("serial number not stored");
	a_serial_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		st_q == S_IDLE && !ctrl_q[CTRL_ABS] |=> sn_q == 32'h0000_0000 && st_q == S_RUN)
		else $error("incremental system kept a serial number");
	c_serial_read: cover property (@(posedge clk_in) st_q == S_SN_WAIT && res_take);
	c_alarm_seen: cover property (@(posedge clk_in) $rose(enc_alarm_out));
	c_parity_bad: cover property (@(posedge clk_in) $rose(par_err_q));
	c_gray_frame: cover property (@(posedge clk_in)
		st_q == S_POS_WAIT && res_take && !cfg_q[CFG_BINARY]);
endmodule
`default_nettype wire

// >>> ssr_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_enc_model (
	input  wire logic        ssi_clk_in,
	input  wire logic [31:0] word_in,
	input  wire logic [5:0]  nbits_in,
	output var  logic        data_out
);
	// A long quiet clock marks the next frame, like the monoflop
	realtime     last_t = 0;
	logic [5:0]  left   = 6'h00;
	logic [31:0] sh     = 32'h0;
	initial data_out = 1'h1;
	// First fall latches the word
	always @(negedge ssi_clk_in) begin
		if ($realtime - last_t > 10000) begin
			sh = word_in;
			left = nbits_in;
		end
		last_t = $realtime;
	end
	// Each rise shows the next bit; a spent line shows no stale value
	always @(posedge ssi_clk_in) begin
		last_t = $realtime;
		if (left != 6'h00) begin
			data_out <= sh[left - 6'h01];
			left = left - 6'h01;
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ssr_pkg::*;
	logic        clk_in = 0;
	logic        lnk_clk = 0;
	logic        rst_b = 0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, mword, rs;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ssi_clk, ssi_data, alarm;
	logic [5:0]  mbits;
	logic [31:0] q_dat[$], q_msk[$];
	logic [1:0]  q_rsp[$], q_brs[$];
	int          fails = 0;
	int          comparisons = 0;
	int          hz[4] = '{100000, 500000, 1000000, 2000000};
	int          ln[4] = '{8, 3, 1, 31};
	logic [15:0] bcf[4] = '{16'h8000, 16'h8A00, 16'h0200, 16'h8200};
	logic [15:0] md[5] = '{16'h0400, 16'h0000, 16'h1000, 16'h7400, 16'h1400};

	// Two clocks, unrelated in phase
	always #5 clk_in = ~clk_in;
	always #80 lnk_clk = ~lnk_clk;

	ssr_reader i_dut (
		.clk_in            (clk_in),
		.rst_b_in          (rst_b),
		.lnk_clk_in        (lnk_clk),
		.s_axi_awaddr_in   (awaddr),
		.s_axi_awvalid_in  (awvalid),
		.s_axi_awready_out (awready),
		.s_axi_wdata_in    (wdata),
		.s_axi_wstrb_in    (wstrb),
		.s_axi_wvalid_in   (wvalid),
		.s_axi_wready_out  (wready),
		.s_axi_bresp_out   (bresp),
		.s_axi_bvalid_out  (bvalid),
		.s_axi_bready_in   (bready),
		.s_axi_araddr_in   (araddr),
		.s_axi_arvalid_in  (arvalid),
		.s_axi_arready_out (arready),
		.s_axi_rdata_out   (rdata),
		.s_axi_rresp_out   (rresp),
		.s_axi_rvalid_out  (rvalid),
		.s_axi_rready_in   (rready),
		.ssi_clk_out       (ssi_clk),
		.ssi_data_in       (ssi_data),
		.enc_alarm_out     (alarm)
	);
	ssr_enc_model i_enc (
		.ssi_clk_in (ssi_clk),
		.word_in    (mword),
		.nbits_in   (mbits),
		.data_out   (ssi_data)
	);

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic bad(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Every wait is counted; running out ends the run
	task automatic bound(ref int n);
		n++;
		if (n > 30000) begin
			bad("timeout");
			stop_test();
		end
	endtask
	task automatic chk(input logic [31:0] g, e, input string m);
		comparisons++;
		if (g !== e)
			bad(m);
	endtask

	// Answers are compared in the order the requests were issued
	always @(posedge clk_in) begin
		if (rvalid && rready) begin
			chk(rdata & q_msk[0], q_dat[0], "read data");
			chk({30'h0, rresp}, {30'h0, q_rsp[0]}, "read resp");
			void'(q_dat.pop_front());
			void'(q_msk.pop_front());
			void'(q_rsp.pop_front());
		end
		if (bvalid && bready) begin
			chk({30'h0, bresp}, {30'h0, q_brs[0]}, "write resp");
			void'(q_brs.pop_front());
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ap, wp;
		int   n;
		@(posedge clk_in);
		q_brs.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		ap = 1'h1;
		wp = 1'h1;
		n = 0;
		while (ap || wp) begin
			@(posedge clk_in);
			bound(n);
			if (ap && awready === 1'h1) begin
				ap = 1'h0;
				awvalid <= 1'h0;
			end
			if (wp && wready === 1'h1) begin
				wp = 1'h0;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		do begin
			@(posedge clk_in);
			bound(n);
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, mk,
		input logic [1:0] r);
		int n;
		@(posedge clk_in);
		q_dat.push_back(e & mk);
		q_msk.push_back(mk);
		q_rsp.push_back(r);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_in);
			bound(n);
		end while (arready !== 1'h1);
		arvalid <= 1'h0;
		do begin
			@(posedge clk_in);
			bound(n);
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
	endtask
	// Idle gap first, so the timed frame starts after the last change
	task automatic meas(output int lo, output int fl);
		int   n, k;
		logic p;
		n = 0;
		k = 0;
		while (k < 600) begin
			@(posedge clk_in);
			bound(n);
			k = (ssi_clk === 1'h1) ? k + 1 : 0;
		end
		while (ssi_clk === 1'h1) begin
			@(posedge lnk_clk);
			#1;
			bound(n);
		end
		lo = 0;
		while (ssi_clk === 1'h0) begin
			@(posedge lnk_clk);
			#1;
			bound(n);
			lo++;
		end
		fl = 1;
		k = 0;
		p = 1'h1;
		while (k < 100) begin
			@(posedge lnk_clk);
			#1;
			bound(n);
			if (p && ssi_clk === 1'h0)
				fl++;
			p = ssi_clk;
			k = (ssi_clk === 1'h1) ? k + 1 : 0;
		end
	endtask

	initial begin
		int          lo, fl, i, pb, sh;
		logic [31:0] w, d, e;
		logic [15:0] c;
		logic        al;
		rs = 32'h000149A8;
		{awaddr, araddr, wdata, awvalid, wvalid} = '0;
		{bready, arvalid, rready, mword} = '0;
		wstrb = 4'hF;
		mbits = 6'h08;
		repeat (16) @(posedge clk_in);
		rst_b <= 1'h1;
		rd(OFS_CFG, 32'h0, 32'hFFFF, RESP_OKAY);
		rd(OFS_LEN, 32'h19, 32'hFFFF, RESP_OKAY);
		wr(OFS_SN, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFS_SN, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		wr(8'h1C, 32'h0, RESP_SLVERR);
		rd(8'h1C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			wr(OFS_CFG, {16'h0, bcf[i]}, RESP_OKAY);
			wr(OFS_LEN, (i == 3) ? 32'h0 : 32'h8, RESP_OKAY);
			rd(OFS_STAT, 32'h8, 32'h8, RESP_OKAY);
		end
		$display("test refused setups done");
		for (i = 0; i < 4; i++) begin
			wr(OFS_LEN, ln[i], RESP_OKAY);
			wr(OFS_CFG, 32'h8600 | (i << 7), RESP_OKAY);
			meas(lo, fl);
			chk(lo, 1000000000 / (2 * hz[i]) / 160, "half");
			chk(fl, ((ln[i] > 25) ? 25 : ln[i]) + 1, "falls");
		end
		$display("test rates done");
		wr(OFS_LEN, 32'h8, RESP_OKAY);
		for (i = 0; i < 5; i++) begin
			// Slower rates too, so both sample points are exercised
			c = 16'h8200 | md[i] | 16'(((i % 4 == 0) ? 3 : i) << 7);
			al = c[14];
			pb = 8 - al - c[12];
			d = xs() & ((32'h1 << pb) - 32'h1);
			w = (d << (int'(al) + int'(c[12]))) | (al << c[12]);
			if (c[12])
				w[0] = (^w) ^ ~c[13] ^ (i == 4);
			e = d;
			if (!c[10])
				for (sh = 1; sh < 32; sh = sh * 2)
					e = e ^ (e >> sh);
			mword <= w;
			wr(OFS_CFG, {16'h0, c}, RESP_OKAY);
			// Second frame: the first one timed has then been decoded
			meas(lo, fl);
			meas(lo, fl);
			rd(OFS_POS, e, 32'hFFFFFFFF, RESP_OKAY);
			rd(OFS_STAT, {29'h0, i == 4, al, 1'h0}, 32'h6, RESP_OKAY);
			chk({31'h0, alarm}, {31'h0, al}, "alarm");
		end
		$display("test decoding done");
		w = xs();
		mword <= w;
		mbits <= 6'h20;
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		meas(lo, fl);
		meas(lo, fl);
		rd(OFS_SN, w, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFS_STAT, 32'h10, 32'h10, RESP_OKAY);
		wr(OFS_CTRL, 32'h2, RESP_OKAY);
		meas(lo, fl);
		meas(lo, fl);
		rd(OFS_SN, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		$display("test serial number done");
		stop_test();
	end
endmodule
`default_nettype wire
